//--- logic/snap_cfg.svh
// offsets, field sizes and codes of the i/o port and snapshot logger
// assumes: included by bare name from the package and the design files
`ifndef SNAP_CFG_SVH
`define SNAP_CFG_SVH
// host port offsets from the card base
`define OFS_INPUT_PORT 4'h2
`define OFS_OUTPUT_PORT 4'h3
`define OFS_CAPTURE_COUNT 4'h4
`define OFS_BASE_FIRST 4'h5
`define OFS_STATUS 4'ha
`define OFS_WORD_COUNT 4'hb
// sizes
`define SNAP_NCNT 5
`define SNAP_FIFO_DEPTH 16
`define SNAP_WORD_W 36
// answer codes
`define ERR_NONE 8'h00
`define ERR_RANGE 8'h0a
// output port limit
`define OUT_MAX 16'sh00ff
`endif

//--- logic/snap_pkg.sv
// types shared by the snapshot logger
// assumes: snap_cfg.svh is on the include path
`include "snap_cfg.svh"
package snap_pkg;
    // store sequencer, gray along idle -> store
    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_STORE = 1'b1} snap_state_e;

    // whole state of the top module
    typedef struct packed {
        logic [7:0] in_latch;
        logic [7:0] out_lines;
        logic [15:0] rdata;
        logic [7:0] err;
        logic [2:0] trig_sync;
        logic [1:0] gate_sync;
        logic [`SNAP_NCNT-1:0][15:0] base;
        logic [`SNAP_NCNT-1:0][15:0] snap;
        logic [14:0] target;
        logic [14:0] words;
        logic active;
        snap_state_e state;
        logic [2:0] idx;
        logic out_valid;
        logic [`SNAP_WORD_W-1:0] out_word;
    } logger_s;
endpackage : snap_pkg

//--- logic/snap_fifo.sv
// word fifo between the store sequencer and the memory write port
// assumes: one clock, producer honours in_ready, consumer drives out_ready
`timescale 1ns/1ps
module snap_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    // power-of-two depth keeps pointer wrap free
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH)
        begin : g_bad_depth
            $error("snap_fifo depth must be a power of two");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_s;

    fifo_s st_reg;
    fifo_s st_next;
    logic push;
    logic pop;

    // honest flags straight from the occupancy count
    assign in_ready = (st_reg.count != (AW + 1)'(DEPTH));
    assign out_valid = (st_reg.count != '0);
    assign out_data = st_reg.mem[st_reg.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // pointer and count update
    always_comb
    begin
        st_next = st_reg;
        if (push)
        begin
            st_next.mem[st_reg.wr] = in_data;
            st_next.wr = st_reg.wr + 1'b1;
        end
        if (pop)
        begin
            st_next.rd = st_reg.rd + 1'b1;
        end
        st_next.count = st_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    // state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end
endmodule : snap_fifo

//--- logic/io_port_and_snapshot_logger.sv
// digital i/o ports and triggered counter snapshot logger
// assumes: host i/o strobes synchronous to clk, counters sampled live,
// memory write port accepts words under valid/ready
//
// Function
// - strobe high makes input port transparent
// - strobe low holds captured input byte
// - read at offset two returns input byte
// - write at offset three drives output lines
// - ports independent of counter state
// - snapshot only on trigger rising edge
// - trigger honoured only while gate low
// - latch selected counters together, then store
// - each trigger stores two bytes further on
// - every counter has own buffer base
// - zero base deselects that counter
// - stop after programmed trigger count reached
// - status shows active flag, words read at own offset
// - capture count at or below zero: error 10
// - output value out of range: error 10
// - bad request does nothing, answers error
`timescale 1ns/1ps
`include "snap_cfg.svh"
module io_port_and_snapshot_logger #(
    parameter int NCNT = 5,
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // host i/o port
    input wire logic [3:0] io_addr,
    input wire logic io_rd,
    input wire logic io_wr,
    input wire logic [15:0] io_wdata,
    output logic [15:0] io_rdata,
    output logic [7:0] err_code,
    // digital port pins
    input wire logic [7:0] input_lines,
    input wire logic in_strobe,
    output logic [7:0] output_lines,
    // trigger pins
    input wire logic trig_in,
    input wire logic trig_gate_n,
    // live counter values
    input wire logic [NCNT-1:0][15:0] counter_values,
    // memory write port: address then data word
    output logic mem_valid,
    output logic [19:0] mem_addr,
    output logic [15:0] mem_data,
    input wire logic mem_ready,
    // status pins
    output logic capture_active
);
    // the packed state fixes the counter count
    generate
        if (NCNT != `SNAP_NCNT || FIFO_DEPTH < 2)
        begin : g_bad_param
            $error("logger parameters do not match the state layout");
        end
    endgenerate

    snap_pkg::logger_s st_reg; // all state
    snap_pkg::logger_s st_next; // its next value
    logic fifo_in_valid; // sequencer offers a word
    logic [`SNAP_WORD_W-1:0] fifo_in_data; // address and data
    logic fifo_in_ready; // stalls the sequencer when full
    logic fifo_out_valid;
    logic [`SNAP_WORD_W-1:0] fifo_out_data;
    logic fifo_out_ready;
    logic trig_rise; // synchronised rising edge
    logic trig_accept; // edge that starts a snapshot
    logic [15:0] cur_base; // base of the counter being stored
    logic count_load; // a legal capture count write restarts the run

    // decode the host address of a given register
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // edge taken from the second and third stage only
    assign trig_rise = st_reg.trig_sync[1] && !st_reg.trig_sync[2];
    assign trig_accept = trig_rise && !st_reg.gate_sync[1] && st_reg.active;
    assign cur_base = st_reg.base[st_reg.idx];
    // segment times sixteen plus two bytes per word already stored
    assign fifo_in_data = {{cur_base, 4'h0} + {4'h0, st_reg.words, 1'b0},
        st_reg.snap[st_reg.idx]};
    assign fifo_in_valid = (st_reg.state == snap_pkg::ST_STORE) && (cur_base != 16'h0000);
    // output stage refills when empty or when memory takes its word
    assign fifo_out_ready = !st_reg.out_valid || mem_ready;
    // the sequencer must see a restart too, so it cannot undo it
    assign count_load = io_wr && hit(io_addr, `OFS_CAPTURE_COUNT)
        && $signed(io_wdata) > 16'sh0000;

    // next-state logic
    always_comb
    begin
        st_next = st_reg;
        // input latch follows the pins only while strobe is high
        if (in_strobe)
        begin
            st_next.in_latch = input_lines;
        end
        // otherwise the captured byte holds
        // synchronisers: stage 0 feeds stage 1 only
        st_next.trig_sync = {st_reg.trig_sync[1:0], trig_in};
        st_next.gate_sync = {st_reg.gate_sync[0], trig_gate_n};
        // host reads
        if (io_rd)
        begin
            st_next.rdata = 16'h0000; // unmapped offsets read zero
            if (hit(io_addr, `OFS_INPUT_PORT))
            begin
                st_next.rdata = {8'h00, st_reg.in_latch};
            end
            else if (hit(io_addr, `OFS_STATUS))
            begin
                st_next.rdata = {15'h0000, st_reg.active};
            end
            else if (hit(io_addr, `OFS_WORD_COUNT))
            begin
                st_next.rdata = {1'b0, st_reg.words};
            end
            else if (io_addr >= `OFS_BASE_FIRST && io_addr < `OFS_STATUS)
            begin
                st_next.rdata = st_reg.base[io_addr - `OFS_BASE_FIRST];
            end
        end
        // host writes: values checked before anything changes
        if (io_wr)
        begin
            st_next.err = `ERR_NONE;
            if (hit(io_addr, `OFS_OUTPUT_PORT))
            begin
                if ($signed(io_wdata) < 16'sh0000 || $signed(io_wdata) > `OUT_MAX)
                begin
                    st_next.err = `ERR_RANGE;
                end
                else
                begin
                    st_next.out_lines = io_wdata[7:0];
                end
            end
            else if (hit(io_addr, `OFS_CAPTURE_COUNT))
            begin
                if ($signed(io_wdata) <= 16'sh0000)
                begin
                    st_next.err = `ERR_RANGE;
                end
                else
                begin
                    // a new run restarts the word count at zero
                    st_next.target = io_wdata[14:0];
                    st_next.words = 15'h0000;
                    st_next.active = 1'b1;
                end
            end
            else if (io_addr >= `OFS_BASE_FIRST && io_addr < `OFS_STATUS)
            begin
                st_next.base[io_addr - `OFS_BASE_FIRST] = io_wdata;
            end
        end
        // store sequencer
        unique case (st_reg.state)
            snap_pkg::ST_IDLE:
            begin
                // all counters latched in one edge
                if (trig_accept)
                begin
                    st_next.snap = counter_values;
                    st_next.idx = 3'h0;
                    st_next.state = snap_pkg::ST_STORE;
                end
            end
            snap_pkg::ST_STORE:
            begin
                // a new edge here is dropped: no branch looks at it
                // zero base skips, full fifo stalls the walk
                if (cur_base == 16'h0000 || fifo_in_ready)
                begin
                    st_next.idx = st_reg.idx + 3'h1;
                    if (st_reg.idx == 3'(NCNT - 1))
                    begin
                        st_next.state = snap_pkg::ST_IDLE;
                        // park the index so the base lookup stays in range
                        st_next.idx = 3'h0;
                        // a run restarted this cycle wins over the old run's count
                        if (!count_load)
                        begin
                            st_next.words = st_reg.words + 15'h0001;
                            if (st_reg.words + 15'h0001 == st_reg.target)
                            begin
                                st_next.active = 1'b0;
                            end
                        end
                    end
                end
            end
        endcase
        // registered memory output stage
        if (fifo_out_ready)
        begin
            st_next.out_valid = fifo_out_valid;
            st_next.out_word = fifo_out_data;
        end
    end

    // state register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // word buffer, back-pressure reaches the sequencer
    snap_fifo #(
        .WIDTH(`SNAP_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready)
    );

    // outputs straight from the state register
    assign io_rdata = st_reg.rdata;
    assign err_code = st_reg.err;
    assign output_lines = st_reg.out_lines;
    assign mem_valid = st_reg.out_valid;
    assign mem_addr = st_reg.out_word[`SNAP_WORD_W-1:16];
    assign mem_data = st_reg.out_word[15:0];
    assign capture_active = st_reg.active;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // port checks
    in_transparent_a: assert property (in_strobe
        |=> st_reg.in_latch == $past(input_lines))
        else $error("input latch not transparent");
    in_hold_a: assert property (!in_strobe |=> $stable(st_reg.in_latch))
        else $error("input latch changed while held");
    in_read_a: assert property (io_rd && io_addr == `OFS_INPUT_PORT
        |=> io_rdata == {8'h00, $past(st_reg.in_latch)})
        else $error("input port read wrong");
    out_write_a: assert property (io_wr && io_addr == `OFS_OUTPUT_PORT
        && io_wdata[15:8] == 8'h00
        |=> {8'h00, output_lines} == $past(io_wdata) && err_code == `ERR_NONE)
        else $error("output port write lost");
    out_reject_a: assert property (io_wr && io_addr == `OFS_OUTPUT_PORT
        && io_wdata[15:8] != 8'h00
        |=> err_code == `ERR_RANGE && $stable(output_lines))
        else $error("bad output value not refused");
    count_reject_a: assert property (io_wr && io_addr == `OFS_CAPTURE_COUNT
        && $signed(io_wdata) <= 16'sh0000
        |=> err_code == `ERR_RANGE && !$rose(capture_active))
        else $error("bad capture count not refused");
    status_read_a: assert property (io_rd && io_addr == `OFS_STATUS
        |=> io_rdata == {15'h0000, $past(capture_active)})
        else $error("status readout wrong");
    count_read_a: assert property (io_rd && io_addr == `OFS_WORD_COUNT
        |=> io_rdata == {1'b0, $past(st_reg.words)})
        else $error("word count readout wrong");

    // trigger and sequencer checks
    sync_delay_a: assert property (trig_rise
        |-> $past(trig_in, 2) && !$past(trig_in, 3))
        else $error("trigger edge not taken through the synchroniser");
    gate_block_a: assert property (st_reg.gate_sync[1]
        && st_reg.state == snap_pkg::ST_IDLE |=> st_reg.state == snap_pkg::ST_IDLE)
        else $error("trigger taken with gate high");
    snap_latch_a: assert property (trig_accept && st_reg.state == snap_pkg::ST_IDLE
        |=> st_reg.state == snap_pkg::ST_STORE && st_reg.snap == $past(counter_values))
        else $error("counters not latched together");
    zero_base_a: assert property (cur_base == 16'h0000
        && st_reg.state == snap_pkg::ST_STORE && !(fifo_out_valid && fifo_out_ready)
        |=> $stable(u_fifo.st_reg.count))
        else $error("deselected counter stored");
    word_step_a: assert property (st_reg.state == snap_pkg::ST_STORE
        && st_reg.idx == 3'(NCNT - 1) && fifo_in_ready && !count_load
        |=> st_reg.words == $past(st_reg.words) + 15'h0001)
        else $error("word count did not step");
    stop_done_a: assert property (!capture_active && st_reg.state == snap_pkg::ST_IDLE
        && !(io_wr && io_addr == `OFS_CAPTURE_COUNT)
        |=> st_reg.state == snap_pkg::ST_IDLE && $stable(st_reg.words))
        else $error("trigger handled after run finished");
    busy_drop_a: assert property (st_reg.state == snap_pkg::ST_STORE && trig_rise
        && st_reg.idx != 3'(NCNT - 1) && !count_load |=> $stable(st_reg.words))
        else $error("busy trigger counted");

    run_start_c: cover property (trig_accept ##1 st_reg.state == snap_pkg::ST_STORE);
    word_out_c: cover property (mem_valid && mem_ready);
    fifo_full_c: cover property (fifo_in_valid && !fifo_in_ready);
    run_end_c: cover property ($fell(capture_active));
    busy_drop_c: cover property (st_reg.state == snap_pkg::ST_STORE && trig_rise);
endmodule : io_port_and_snapshot_logger

//--- testbench/mem_model.sv
// memory model on the logger's snapshot write port; keeps every word it takes
// assumes: same clock as the logger, a word stands under mem_valid until mem_ready
`timescale 1ns/1ps
module mem_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write port
    input wire logic mem_valid,
    input wire logic [19:0] mem_addr,
    input wire logic [15:0] mem_data,
    output logic mem_ready,
    // stall control from the bench
    input wire logic slow
);
    logic [19:0] addr_q[$]; // accepted addresses, oldest first
    logic [15:0] data_q[$]; // accepted data words, same order
    logic phase; // alternates so a slow memory takes one word in two cycles

    // a word is taken only at an edge where valid and ready are both high
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase <= 1'b0;
        end
        else
        begin
            phase <= ~phase;
            if (mem_valid && mem_ready)
            begin
                addr_q.push_back(mem_addr);
                data_q.push_back(mem_data);
            end
        end
    end

    // slow mode backs the fifo up, which a prompt memory never does
    assign mem_ready = slow ? phase : 1'b1;
endmodule : mem_model

//--- testbench/test_io_port_and_snapshot_logger.sv
// self-checking bench for the i/o port and snapshot logger
// assumes: mem_model answers the write port, host strobes last one cycle
`timescale 1ns/1ps
`include "snap_cfg.svh"
module test_io_port_and_snapshot_logger;
    typedef struct {logic [3:0] a; logic [15:0] d; logic [7:0] o; logic [7:0] e;} row_s;
    logic clk, nrst, io_rd, io_wr, in_strobe, trig_in, trig_gate_n, slow;
    logic mem_valid, mem_ready, capture_active;
    logic [3:0] io_addr;
    logic [15:0] io_wdata, io_rdata, mem_data, v;
    logic [7:0] err_code, input_lines, output_lines;
    logic [4:0][15:0] counter_values;
    logic [19:0] mem_addr;
    int mismatches, samples_checked;
    // a 50 MHz clock over 4000 triggers per second: least spacing of real triggers
    localparam int TRIG_GAP = 12500;
    // buffer bases; zero leaves counters 1 and 3 out
    logic [15:0] bases [5] = '{16'h1000, 16'h0000, 16'h2000, 16'h0000, 16'h0300};
    // host writes and the port state that each should leave
    row_s rows [8] = '{
        '{`OFS_OUTPUT_PORT, 16'h0000, 8'h00, `ERR_NONE},
        '{`OFS_OUTPUT_PORT, 16'h00ff, 8'hff, `ERR_NONE},
        '{`OFS_OUTPUT_PORT, 16'h005a, 8'h5a, `ERR_NONE},
        '{`OFS_OUTPUT_PORT, 16'h0100, 8'h5a, `ERR_RANGE},
        '{`OFS_OUTPUT_PORT, 16'hffff, 8'h5a, `ERR_RANGE},
        '{`OFS_CAPTURE_COUNT, 16'h0000, 8'h5a, `ERR_RANGE},
        '{`OFS_CAPTURE_COUNT, 16'h8000, 8'h5a, `ERR_RANGE},
        '{`OFS_INPUT_PORT, 16'h0077, 8'h5a, `ERR_NONE}
    };

    io_port_and_snapshot_logger #(.NCNT(5), .FIFO_DEPTH(`SNAP_FIFO_DEPTH)) DUT (
        .clk(clk), .nrst(nrst), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .err_code(err_code),
        .input_lines(input_lines), .in_strobe(in_strobe), .output_lines(output_lines),
        .trig_in(trig_in), .trig_gate_n(trig_gate_n), .counter_values(counter_values),
        .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_data(mem_data),
        .mem_ready(mem_ready), .capture_active(capture_active)
    );
    mem_model mem (
        .clk(clk), .nrst(nrst), .mem_valid(mem_valid), .mem_addr(mem_addr),
        .mem_data(mem_data), .mem_ready(mem_ready), .slow(slow)
    );

    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic finish_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic chk(input string n, input logic [19:0] exp, input logic [19:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    // one-cycle host write; the answer has landed 1 ns after the taking edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
        #1;
        d = io_rdata;
    endtask : rd

    task automatic pulse(input int hi);
        @(posedge clk);
        trig_in <= 1'b1;
        repeat (hi) @(posedge clk);
        trig_in <= 1'b0;
    endtask : pulse

    // snapshot k of the run: k tags the counter values and is the word count after
    task automatic shot(input int k, input int hi, input bit twice);
        int i;
        int t;
        @(posedge clk);
        for (i = 0; i < 5; i++)
            counter_values[i] <= 16'(k * 16'h1000 + i);
        repeat (TRIG_GAP) @(posedge clk);
        pulse(hi);
        // a second rise while the first walk runs must be lost
        if (twice)
            pulse(2);
        for (t = 0; t < 200 && mem.addr_q.size() < 3; t++)
            @(posedge clk);
        if (mem.addr_q.size() < 3)
        begin
            chk("words offered", 3, mem.addr_q.size());
            finish_test();
        end
        for (i = 0; i < 5; i++)
            if (bases[i] != 16'h0000)
            begin
                chk("mem addr", {bases[i], 4'h0} + 20'(2 * (k - 1)), mem.addr_q.pop_front());
                chk("mem data", 20'(k * 16'h1000 + i), mem.data_q.pop_front());
            end
        repeat (30) @(posedge clk);
        chk("spare words", 0, mem.addr_q.size());
        rd(`OFS_WORD_COUNT, v);
        chk("word count", k, v);
    endtask : shot

    initial
    begin
        nrst = 1'b0;
        io_rd = 1'b0;
        io_wr = 1'b0;
        io_addr = 4'h0;
        io_wdata = 16'h0000;
        input_lines = 8'ha5;
        in_strobe = 1'b1;
        trig_in = 1'b0;
        trig_gate_n = 1'b0;
        slow = 1'b0;
        counter_values = '0;
        mismatches = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("reset outputs", 0, {output_lines, err_code, capture_active, mem_valid});
        // host writes to output port, good and refused, then refused capture counts and an input port write
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            chk("output lines", rows[i].o, output_lines);
            chk("error code", rows[i].e, err_code);
            chk("capture active", 0, capture_active);
        end
        // input latch: live while strobe high, frozen once it falls
        rd(`OFS_INPUT_PORT, v);
        chk("input live", 16'h00a5, v);
        @(posedge clk);
        input_lines <= 8'h3c;
        rd(`OFS_INPUT_PORT, v);
        chk("input live", 16'h003c, v);
        @(posedge clk);
        in_strobe <= 1'b0;
        @(posedge clk);
        input_lines <= 8'hff;
        rd(`OFS_INPUT_PORT, v);
        chk("input held", 16'h003c, v);
        rd(4'hf, v);
        chk("unmapped read", 0, v);
        // capture run of three snapshots
        foreach (bases[i])
            wr(4'(`OFS_BASE_FIRST + i), bases[i]);
        rd(4'(`OFS_BASE_FIRST + 2), v);
        chk("base readback", bases[2], v);
        wr(`OFS_CAPTURE_COUNT, 16'h0003);
        rd(`OFS_STATUS, v);
        chk("status active", 1, v[0]);
        @(posedge clk);
        slow <= 1'b1;
        shot(1, 2, 1'b0);
        @(posedge clk);
        slow <= 1'b0;
        // ports keep working while capture runs
        rd(`OFS_INPUT_PORT, v);
        chk("input during run", 16'h003c, v);
        wr(`OFS_OUTPUT_PORT, 16'h0081);
        chk("output during run", 8'h81, output_lines);
        // gate high: trigger ignored
        @(posedge clk);
        trig_gate_n <= 1'b1;
        repeat (TRIG_GAP) @(posedge clk);
        pulse(2);
        repeat (30) @(posedge clk);
        rd(`OFS_WORD_COUNT, v);
        chk("gated count", 1, v);
        chk("gated words", 0, mem.addr_q.size());
        @(posedge clk);
        trig_gate_n <= 1'b0;
        shot(2, 2, 1'b1);
        shot(3, 12, 1'b0);
        chk("active after run", 0, capture_active);
        rd(`OFS_STATUS, v);
        chk("status finished", 0, v[0]);
        // further triggers are not served once the count is reached
        repeat (TRIG_GAP) @(posedge clk);
        pulse(2);
        repeat (30) @(posedge clk);
        chk("words after end", 0, mem.addr_q.size());
        rd(`OFS_WORD_COUNT, v);
        chk("final count", 3, v);
        // reset in mid-run clears the run, the ports and the word count
        wr(`OFS_CAPTURE_COUNT, 16'h0002);
        chk("active before reset", 1, capture_active);
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        #1;
        chk("outputs in reset", 0, {output_lines, err_code, capture_active, mem_valid});
        @(posedge clk);
        nrst <= 1'b1;
        rd(`OFS_WORD_COUNT, v);
        chk("count after reset", 0, v);
        finish_test();
    end
endmodule : test_io_port_and_snapshot_logger
